// ===== bench/scl_card.sv
// behavioural card on the open-drain data line, paced by the card clock
`timescale 1ns/1ps
`default_nettype none
module scl_card (
    input  wire logic       sck_in,
    input  wire logic       line_in,
    input  wire logic       nack_in,
    output var  logic       pull_out,
    output var  logic [7:0] got_out,
    output var  logic       par_out,
    output var  logic [7:0] cnt_out,
    output var  logic       seen_out
);
    logic busy = 1'b0;
    // one card clock per base tick, so 186 of them make half a bit
    task automatic halves(input int n);
        repeat (n * 186) @(posedge sck_in);
    endtask
    task automatic send(input logic [7:0] b, input logic bad);
        busy = 1'b1;
        pull_out = 1'b1;
        halves(2);
        for (int i = 0; i < 8; i++) begin
            pull_out = ~b[i];
            halves(2);
        end
        pull_out = ~(^b ^ bad);
        halves(2);
        pull_out = 1'b0;
        halves(2);
        seen_out = ~line_in;
        halves(2);
        busy = 1'b0;
    endtask
    initial begin
        pull_out = 1'b0;
        got_out = 8'h00;
        par_out = 1'b0;
        cnt_out = 8'h00;
        seen_out = 1'b0;
        forever begin
            @(negedge line_in iff !busy);
            halves(1);
            for (int i = 0; i < 8; i++) begin
                halves(2);
                got_out[i] = line_in;
            end
            halves(2);
            par_out = line_in;
            cnt_out = cnt_out + 8'h01;
            halves(2);
            if (nack_in) begin
                pull_out = 1'b1;
                halves(2);
                pull_out = 1'b0;
            end
        end
    end
endmodule // scl_card
`default_nettype wire

// ===== bench/scl_link_props.sv
// assertion checker for the smart card link bus, pins and interrupt lines
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.vh"
module scl_link_props (
    input wire logic        clock_in,
    input wire logic        resetn_in,
    input wire logic [2:0]  wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic        wb_we_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_ack_out,
    input wire logic        data_pin_oe_out,
    input wire logic        sck_pin_out,
    input wire logic        sck_pin_oe_out,
    input wire logic        tx_ready_irq_out,
    input wire logic        rx_full_irq_out,
    input wire logic        comm_fault_irq_out,
    input wire logic        tx_end_irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    logic [7:0] mode_ff, ctrl_ff, cmode_ff;
    wire logic  wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0];
    // shadow controls, updated on the same edge the design applies a write
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_ff <= 8'h00;
            ctrl_ff <= 8'h00;
            cmode_ff <= 8'h00;
        end else if (wr) begin
            if (wb_adr_in == `SCL_IDX_MODE) mode_ff <= wb_dat_in[7:0];
            if (wb_adr_in == `SCL_IDX_CTRL) ctrl_ff <= wb_dat_in[7:0];
            if (wb_adr_in == `SCL_IDX_CARDMODE) cmode_ff <= wb_dat_in[7:0];
        end
    end
    sequence req_s;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence start_s;
        wr && wb_adr_in == `SCL_IDX_STATUS && !wb_dat_in[`SCL_STAT_TX_EMPTY];
    endsequence
    ack_timing_a: assert property (req_s |=> wb_ack_out) else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
    tx_end_never_a: assert property (cmode_ff[`SCL_CMODE_CARD] |-> !tx_end_irq_out)
        else $error("tx end irq in card mode");
    tx_mask_a: assert property (!ctrl_ff[`SCL_CTRL_TX_IRQ_EN] |-> !tx_ready_irq_out)
        else $error("tx ready irq while masked");
    rx_mask_a: assert property (!ctrl_ff[`SCL_CTRL_RX_IRQ_EN] |-> !rx_full_irq_out && !comm_fault_irq_out)
        else $error("receive or fault irq while masked");
    tx_start_a: assert property (start_s |=> !tx_ready_irq_out [*8])
        else $error("tx done not cleared by start");
    oe_idle_a: assert property (!ctrl_ff[`SCL_CTRL_TX_EN] && !ctrl_ff[`SCL_CTRL_RX_EN] |=> !data_pin_oe_out)
        else $error("data pin driven while idle");
    sck_run_a: assert property (cmode_ff[`SCL_CMODE_CARD] && ctrl_ff[`SCL_CTRL_CLK_EN] && mode_ff[1:0] == 2'h0
        |-> ##[1:600] sck_pin_oe_out && $changed(sck_pin_out)) else $error("card clock not running");
endmodule // scl_link_props
bind scl_link scl_link_props chk_u (
    .clock_in(clock_in), .resetn_in(resetn_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
    .wb_sel_in(wb_sel_in), .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_ack_out(wb_ack_out), .data_pin_oe_out(data_pin_oe_out), .sck_pin_out(sck_pin_out),
    .sck_pin_oe_out(sck_pin_oe_out), .tx_ready_irq_out(tx_ready_irq_out), .rx_full_irq_out(rx_full_irq_out),
    .comm_fault_irq_out(comm_fault_irq_out), .tx_end_irq_out(tx_end_irq_out)
);
`default_nettype wire

// ===== bench/test_scl_link.sv
// self-checking bench for the smart card serial link
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.vh"
module test_scl_link;
    logic        clock_in, resetn_in, cyc, stb, we, ack, nack, pull, oe, dout, sck, sck_oe;
    logic        irq_tx, irq_rx, irq_err, irq_end, seen, gpar;
    logic [2:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [7:0]  got, q, cnt, c0;
    int          num_errors = 0, tests_run = 0, cycles = 0;
    logic [2:0]  ri [5] = '{3'h4, 3'h1, 3'h2, 3'h7, 3'h6};
    logic [7:0]  rexp [5] = '{8'h84, 8'hff, 8'h00, 8'h00, 8'h00};
    wire logic   line = (oe ? dout : 1'b1) & ~pull;
    scl_link dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .wb_adr_in(adr), .wb_dat_in(wdat),
        .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(rdat), .wb_ack_out(ack),
        .data_pin_in(line), .data_pin_out(dout), .data_pin_oe_out(oe), .sck_pin_out(sck), .sck_pin_oe_out(sck_oe),
        .tx_ready_irq_out(irq_tx), .rx_full_irq_out(irq_rx), .comm_fault_irq_out(irq_err), .tx_end_irq_out(irq_end));
    scl_card card_u (.sck_in(sck), .line_in(line), .nack_in(nack), .pull_out(pull), .got_out(got),
        .par_out(gpar), .cnt_out(cnt), .seen_out(seen));
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // entered just after a rising edge; returns just after one
    task automatic wb(input logic [2:0] a, input logic w, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do @(posedge clock_in); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic wait_st(input logic [7:0] m);
        do wb(`SCL_IDX_STATUS, 1'b0, 8'h00); while ((q & m) === 8'h00);
    endtask
    task automatic tx(input logic [7:0] d);
        wb(`SCL_IDX_TXDATA, 1'b1, d);
        wb(`SCL_IDX_STATUS, 1'b1, 8'h7f);
        chk1(irq_tx, 1'b0);
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // six frames of 12 bits at 744 clocks each need about 54k cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            wrap_up;
        end
    end
    initial begin
        {resetn_in, cyc, stb, we, nack} = 5'h00;
        adr = 3'h0;
        sel = 4'h1;
        wdat = 32'h00000000;
        repeat (10) @(posedge clock_in);
        resetn_in <= 1'b1;
        @(posedge clock_in);
        wb(3'h7, 1'b1, 8'hff);
        for (int i = 0; i < 5; i++) begin
            wb(ri[i], 1'b0, 8'h00);
            chk8(q, rexp[i]);
        end
        wb(`SCL_IDX_CTRL, 1'b1, 8'h00);
        wb(`SCL_IDX_STATUS, 1'b1, 8'hc7);
        wb(`SCL_IDX_MODE, 1'b1, 8'h28);
        wb(`SCL_IDX_CARDMODE, 1'b1, 8'h01);
        wb(`SCL_IDX_BITRATE, 1'b1, 8'h00);
        wb(`SCL_IDX_CTRL, 1'b1, 8'h01);
        chk1(oe, 1'b0);
        repeat (800) @(posedge clock_in);
        chk1(sck_oe, 1'b1);
        wb(`SCL_IDX_CTRL, 1'b1, 8'he5);
        wait_st(8'h04);
        tx(8'ha5);
        wait_st(8'h04);
        chk8(got, 8'ha5);
        chk1(gpar, ^8'ha5);
        chk8(q, 8'h84);
        chk1(irq_tx, 1'b1);
        c0 = cnt;
        nack <= 1'b1;
        tx(8'h3c);
        wait_st(8'h10);
        chk8(q & 8'h14, 8'h10);
        chk1(irq_err, 1'b1);
        nack <= 1'b0;
        wb(`SCL_IDX_STATUS, 1'b1, 8'hef);
        wait_st(8'h04);
        chk8(got, 8'h3c);
        chk8(cnt - c0, 8'h02);
        chk1(irq_end, 1'b0);
        wb(`SCL_IDX_CTRL, 1'b1, 8'h01);
        wb(`SCL_IDX_STATUS, 1'b1, 8'hc7);
        wb(`SCL_IDX_CTRL, 1'b1, 8'h51);
        card_u.send(8'h5a, 1'b0);
        @(posedge clock_in);
        wait_st(8'h40);
        chk8(q, 8'hc4);
        chk1(irq_rx, 1'b1);
        chk1(seen, 1'b0);
        wb(`SCL_IDX_RXDATA, 1'b0, 8'h00);
        chk8(q, 8'h5a);
        wb(`SCL_IDX_STATUS, 1'b1, 8'hbf);
        card_u.send(8'h96, 1'b1);
        @(posedge clock_in);
        chk1(seen, 1'b1);
        wb(`SCL_IDX_STATUS, 1'b0, 8'h00);
        chk8(q, 8'h8c);
        chk1(irq_err, 1'b1);
        wb(`SCL_IDX_RXDATA, 1'b0, 8'h00);
        chk8(q, 8'h96);
        wb(`SCL_IDX_STATUS, 1'b1, 8'hf7);
        wb(`SCL_IDX_STATUS, 1'b0, 8'h00);
        chk8(q, 8'h84);
        chk1(irq_err, 1'b0);
        // inverse convention transmit right after a bad-parity receive
        wb(`SCL_IDX_CTRL, 1'b1, 8'h01);
        wb(`SCL_IDX_STATUS, 1'b1, 8'hc7);
        wb(`SCL_IDX_MODE, 1'b1, 8'h38);
        wb(`SCL_IDX_CARDMODE, 1'b1, 8'h0d);
        wb(`SCL_IDX_CTRL, 1'b1, 8'ha1);
        tx(8'h4e);
        wait_st(8'h04);
        chk8(q & 8'h14, 8'h04);
        chk8(got, 8'h8d);
        chk1(gpar, 1'b1);
        wrap_up;
    end
endmodule // test_scl_link
`default_nettype wire

// ===== src/scl_baud.v
// base clock divider: half-period pulse of the 372x bit rate clock
`timescale 1ns/1ps
`default_nettype none
module scl_baud #(
    parameter PW = 6,
    parameter DW = 8
) (
    input  wire          clock_in,
    input  wire          resetn_in,
    input  wire [1:0]    prescale_sel_in,
    input  wire [DW-1:0] divisor_in,
    output reg           half_tick_out
);
    reg [PW-1:0] pre_ff;
    reg [DW-1:0] div_ff;

    // prescaler length is 4^n cycles
    function [PW-1:0] pre_limit;
        input [1:0] n;
        begin
            case (n)
                2'h0:    pre_limit = 6'h00;
                2'h1:    pre_limit = 6'h03;
                2'h2:    pre_limit = 6'h0f;
                default: pre_limit = 6'h3f;
            endcase
        end
    endfunction

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_ff        <= {PW{1'b0}};
            div_ff        <= {DW{1'b0}};
            half_tick_out <= 1'b0;
        end else begin
            half_tick_out <= 1'b0;
            if (pre_ff >= pre_limit(prescale_sel_in)) begin
                pre_ff <= {PW{1'b0}};
                // >= so a smaller divisor written mid-count cannot stall
                if (div_ff >= divisor_in) begin
                    div_ff        <= {DW{1'b0}};
                    half_tick_out <= 1'b1;
                end else begin
                    div_ff <= div_ff + 1'b1;
                end
            end else begin
                pre_ff <= pre_ff + 1'b1;
            end
        end
    end
endmodule // scl_baud
`default_nettype wire

// ===== src/scl_defs.vh
// register map, field positions, reset values and frame timing of the smart card link
`ifndef SCL_DEFS_VH
`define SCL_DEFS_VH

// register indices; byte address is four times the index
`define SCL_IDX_MODE      3'h0
`define SCL_IDX_BITRATE   3'h1
`define SCL_IDX_CTRL      3'h2
`define SCL_IDX_TXDATA    3'h3
`define SCL_IDX_STATUS    3'h4
`define SCL_IDX_RXDATA    3'h5
`define SCL_IDX_CARDMODE  3'h6

// serial_mode_reg fields
`define SCL_MODE_DONE_TIMING 7
`define SCL_MODE_PARITY_ODD  4
`define SCL_MODE_PRESCALE_HI 1
`define SCL_MODE_PRESCALE_LO 0

// serial_control_reg fields
`define SCL_CTRL_TX_IRQ_EN   7
`define SCL_CTRL_RX_IRQ_EN   6
`define SCL_CTRL_TX_EN       5
`define SCL_CTRL_RX_EN       4
`define SCL_CTRL_TX_END_IRQ  2
`define SCL_CTRL_CLK_LEVEL   1
`define SCL_CTRL_CLK_EN      0

// serial_status_reg fields
`define SCL_STAT_TX_EMPTY    7
`define SCL_STAT_RX_FULL     6
`define SCL_STAT_OVERRUN     5
`define SCL_STAT_ERR_SIG     4
`define SCL_STAT_PARITY      3
`define SCL_STAT_TX_DONE     2

// card_mode_reg fields
`define SCL_CMODE_BIT_ORDER  3
`define SCL_CMODE_INVERT     2
`define SCL_CMODE_CARD       0

// reset values
`define SCL_RST_MODE      8'h00
`define SCL_RST_BITRATE   8'hff
`define SCL_RST_CTRL      8'h00
`define SCL_RST_CARDMODE  8'h00

// frame timing in base clock cycles and bit slots
`define SCL_BASE_LAST     9'h173
`define SCL_SAMPLE_PT     9'h0b9
`define SCL_SLOT_PARITY   4'h9
`define SCL_SLOT_ERRSIG   4'ha
`define SCL_SLOT_LAST     4'hb

`endif

// ===== src/scl_link.v
// half-duplex smart card serial link with wishbone register slave
// Functional notes
// - card mode select hands the data and clock pins to the link, released (high-Z)
// - clock output enable drives the card clock on the clock pin
// - starting a transmission clears tx done
// - error signal during transmit raises comm fault irq when rx irq enabled
// - overrun or parity error in receive raises comm fault irq when enabled
// - byte with parity error is still stored in receive data register
// - card mode never raises tx end irq; only three irq sources
// - start edge found on 372x base clock; bits latched at 186th cycle
// - parity error sets parity flag and does not set rx full
// - good parity: parity flag stays clear, rx full set, rx irq requested
// - after a good frame the data pin stays released in error slot
// - returned error signal sets error flag and withholds tx done
// - no error signal: tx done set at frame end, tx irq requested
// - after an error signal the same byte is resent, else next byte
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.vh"
module scl_link (
    input  wire        clock_in,
    input  wire        resetn_in,
    input  wire [2:0]  wb_adr_in,
    input  wire [31:0] wb_dat_in,
    input  wire [3:0]  wb_sel_in,
    input  wire        wb_we_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    input  wire        data_pin_in,
    output wire        data_pin_out,
    output reg         data_pin_oe_out,
    output reg         sck_pin_out,
    output reg         sck_pin_oe_out,
    output wire        tx_ready_irq_out,
    output wire        rx_full_irq_out,
    output wire        comm_fault_irq_out,
    output wire        tx_end_irq_out
);
    reg  [7:0] mode_ff;
    reg  [7:0] bitrate_ff;
    reg  [7:0] ctrl_ff;
    reg  [7:0] txdata_ff;
    reg  [7:0] rxdata_ff;
    reg  [7:0] cmode_ff;
    reg        tx_buf_empty_ff;
    reg        rx_buf_full_ff;
    reg        overrun_ff;
    reg        err_sig_ff;
    reg        parity_err_ff;
    reg        tx_done_ff;
    reg        sync1_ff;
    reg        sync2_ff;
    reg        line_prev_ff;
    reg        phase_ff;
    reg        sck_ff;
    reg        busy_ff;
    reg        dir_tx_ff;
    reg        retry_ff;
    reg        bad_par_ff;
    reg        err_drive_ff;
    reg  [3:0] slot_ff;
    reg  [8:0] cnt_ff;
    reg  [8:0] shift_ff;
    reg  [7:0] txbyte_ff;
    reg        nxt_drive;
    reg  [7:0] rd_data;
    wire       half_tick;
    wire       base_tick;
    wire       card_mode;
    wire       parity_odd;
    wire       bus_hit;
    wire       wr_en;
    wire       wr_stat;
    wire [7:0] tx_word;
    wire [7:0] rx_word;
    wire [8:0] rx_shifted;

    // bit order and level mapping; an involution, so shared by tx and rx
    function [7:0] conv_map;
        input [7:0] b;
        input       msb_first;
        input       inv;
        reg   [7:0] r;
        integer     i;
        begin
            r = b;
            for (i = 0; i < 8; i = i + 1) begin
                if (msb_first)
                    r[i] = b[7-i];
            end
            conv_map = r ^ {8{inv}};
        end
    endfunction

    // parity bit on line levels that makes the total even or odd
    function par_bit;
        input [7:0] w;
        input       odd;
        begin
            par_bit = (^w) ^ odd;
        end
    endfunction

    assign card_mode  = cmode_ff[`SCL_CMODE_CARD];
    assign parity_odd = mode_ff[`SCL_MODE_PARITY_ODD];
    assign bus_hit    = wb_cyc_in & wb_stb_in;
    assign wr_en      = bus_hit & wb_we_in & wb_ack_out & wb_sel_in[0];
    assign wr_stat    = wr_en & (wb_adr_in == `SCL_IDX_STATUS);
    assign tx_word    = conv_map(retry_ff ? txbyte_ff : txdata_ff,
                                 cmode_ff[`SCL_CMODE_BIT_ORDER], cmode_ff[`SCL_CMODE_INVERT]);
    assign rx_word    = conv_map(shift_ff[8:1],
                                 cmode_ff[`SCL_CMODE_BIT_ORDER], cmode_ff[`SCL_CMODE_INVERT]);
    assign rx_shifted = {sync2_ff, shift_ff[8:1]};
    assign base_tick  = half_tick & phase_ff;
    // open drain line: only ever pulled low
    assign data_pin_out = 1'b0;

    scl_baud #(
        .PW (6),
        .DW (8)
    ) u_baud (
        .clock_in        (clock_in),
        .resetn_in       (resetn_in),
        .prescale_sel_in ({mode_ff[`SCL_MODE_PRESCALE_HI], mode_ff[`SCL_MODE_PRESCALE_LO]}),
        .divisor_in      (bitrate_ff),
        .half_tick_out   (half_tick)
    );

    // interrupt requests are levels of flag and mask
    assign tx_ready_irq_out   = tx_done_ff & ctrl_ff[`SCL_CTRL_TX_IRQ_EN];
    assign rx_full_irq_out    = rx_buf_full_ff & ctrl_ff[`SCL_CTRL_RX_IRQ_EN];
    assign comm_fault_irq_out = (err_sig_ff | parity_err_ff | overrun_ff)
                                & ctrl_ff[`SCL_CTRL_RX_IRQ_EN];
    assign tx_end_irq_out     = tx_done_ff & ctrl_ff[`SCL_CTRL_TX_END_IRQ] & ~card_mode;

    // read mux; unmapped words read zero
    always @* begin
        case (wb_adr_in)
            `SCL_IDX_MODE:     rd_data = mode_ff;
            `SCL_IDX_BITRATE:  rd_data = bitrate_ff;
            `SCL_IDX_CTRL:     rd_data = ctrl_ff;
            `SCL_IDX_TXDATA:   rd_data = txdata_ff;
            `SCL_IDX_STATUS:   rd_data = {tx_buf_empty_ff, rx_buf_full_ff, overrun_ff,
                                          err_sig_ff, parity_err_ff, tx_done_ff, 2'h0};
            `SCL_IDX_RXDATA:   rd_data = rxdata_ff;
            `SCL_IDX_CARDMODE: rd_data = {4'h0, cmode_ff[3:2], 1'b0, cmode_ff[0]};
            default:           rd_data = 8'h00;
        endcase
    end

    // ack one cycle after the request, dropped the cycle after
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            mode_ff    <= `SCL_RST_MODE;
            bitrate_ff <= `SCL_RST_BITRATE;
            ctrl_ff    <= `SCL_RST_CTRL;
            txdata_ff  <= 8'h00;
            cmode_ff   <= `SCL_RST_CARDMODE;
        end else begin
            wb_ack_out <= bus_hit & ~wb_ack_out;
            if (bus_hit & ~wb_ack_out)
                wb_dat_out <= {24'h000000, rd_data};
            if (wr_en) begin
                case (wb_adr_in)
                    `SCL_IDX_MODE:     mode_ff    <= wb_dat_in[7:0];
                    `SCL_IDX_BITRATE:  bitrate_ff <= wb_dat_in[7:0];
                    `SCL_IDX_CTRL:     ctrl_ff    <= wb_dat_in[7:0];
                    `SCL_IDX_TXDATA:   txdata_ff  <= wb_dat_in[7:0];
                    `SCL_IDX_CARDMODE: cmode_ff   <= {4'h0, wb_dat_in[3:2], 1'b0, wb_dat_in[0]};
                    default:           cmode_ff   <= cmode_ff;
                endcase
            end
        end
    end

    // pin synchroniser and card clock
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_ff       <= 1'b1;
            sync2_ff       <= 1'b1;
            phase_ff       <= 1'b0;
            sck_ff         <= 1'b0;
            sck_pin_out    <= 1'b0;
            sck_pin_oe_out <= 1'b0;
        end else begin
            sync1_ff <= data_pin_in;
            sync2_ff <= sync1_ff;
            if (half_tick) begin
                phase_ff <= ~phase_ff;
                sck_ff   <= ~sck_ff;
            end
            // stopping the clock keeps the divider phase, so duty stays constant
            sck_pin_out    <= ctrl_ff[`SCL_CTRL_CLK_EN] ? sck_ff : ctrl_ff[`SCL_CTRL_CLK_LEVEL];
            sck_pin_oe_out <= card_mode & (ctrl_ff[`SCL_CTRL_CLK_EN] | mode_ff[`SCL_MODE_DONE_TIMING]);
        end
    end

    // line drive: start and zero bits in transmit, error slot in receive
    always @* begin
        nxt_drive = 1'b0;
        if (busy_ff & dir_tx_ff) begin
            if (slot_ff == 4'h0)
                nxt_drive = 1'b1;
            else if (slot_ff <= `SCL_SLOT_PARITY)
                nxt_drive = ~shift_ff[slot_ff - 4'h1];
        end else if (busy_ff) begin
            nxt_drive = err_drive_ff;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in)
            data_pin_oe_out <= 1'b0;
        else
            data_pin_oe_out <= card_mode & nxt_drive;
    end

    // frame engine and status flags; hardware sets come after software clears
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_buf_empty_ff <= 1'b1;
            rx_buf_full_ff  <= 1'b0;
            overrun_ff      <= 1'b0;
            err_sig_ff      <= 1'b0;
            parity_err_ff   <= 1'b0;
            tx_done_ff      <= 1'b1;
            rxdata_ff       <= 8'h00;
            line_prev_ff    <= 1'b1;
            busy_ff         <= 1'b0;
            dir_tx_ff       <= 1'b0;
            retry_ff        <= 1'b0;
            bad_par_ff      <= 1'b0;
            err_drive_ff    <= 1'b0;
            slot_ff         <= 4'h0;
            cnt_ff          <= 9'h000;
            shift_ff        <= 9'h000;
            txbyte_ff       <= 8'h00;
        end else begin
            if (wr_stat) begin
                if (!wb_dat_in[`SCL_STAT_TX_EMPTY]) begin
                    tx_buf_empty_ff <= 1'b0;
                    tx_done_ff      <= 1'b0;
                end
                if (!wb_dat_in[`SCL_STAT_RX_FULL])
                    rx_buf_full_ff <= 1'b0;
                if (!wb_dat_in[`SCL_STAT_OVERRUN])
                    overrun_ff <= 1'b0;
                if (!wb_dat_in[`SCL_STAT_ERR_SIG])
                    err_sig_ff <= 1'b0;
                if (!wb_dat_in[`SCL_STAT_PARITY])
                    parity_err_ff <= 1'b0;
            end
            if (base_tick) begin
                line_prev_ff <= sync2_ff;
                if (!busy_ff) begin
                    slot_ff    <= 4'h0;
                    cnt_ff     <= 9'h000;
                    bad_par_ff <= 1'b0;
                    if (card_mode & ctrl_ff[`SCL_CTRL_TX_EN] & (retry_ff | ~tx_buf_empty_ff)) begin
                        busy_ff   <= 1'b1;
                        dir_tx_ff <= 1'b1;
                        shift_ff  <= {par_bit(tx_word, parity_odd), tx_word};
                        if (!retry_ff) begin
                            txbyte_ff       <= txdata_ff;
                            tx_buf_empty_ff <= 1'b1;
                        end
                    end else if (card_mode & ctrl_ff[`SCL_CTRL_RX_EN] & line_prev_ff & ~sync2_ff) begin
                        busy_ff      <= 1'b1;
                        dir_tx_ff    <= 1'b0;
                        err_drive_ff <= 1'b0;
                    end
                end else begin
                    if (cnt_ff == `SCL_BASE_LAST) begin
                        cnt_ff  <= 9'h000;
                        slot_ff <= slot_ff + 4'h1;
                    end else begin
                        cnt_ff <= cnt_ff + 9'h001;
                    end
                    if (dir_tx_ff) begin
                        // error signal sampled at the start of the last slot
                        if (slot_ff == `SCL_SLOT_LAST && cnt_ff == 9'h000 && !sync2_ff)
                            bad_par_ff <= 1'b1;
                        if (slot_ff == `SCL_SLOT_LAST && cnt_ff == `SCL_BASE_LAST) begin
                            busy_ff    <= 1'b0;
                            bad_par_ff <= 1'b0;
                            if (bad_par_ff) begin
                                err_sig_ff <= 1'b1;
                                retry_ff   <= 1'b1;
                            end else begin
                                retry_ff   <= 1'b0;
                                tx_done_ff <= 1'b1;
                            end
                        end
                    end else if (cnt_ff == `SCL_SAMPLE_PT) begin
                        if (slot_ff == 4'h0) begin
                            // glitch, not a start bit
                            if (sync2_ff)
                                busy_ff <= 1'b0;
                        end else if (slot_ff < `SCL_SLOT_PARITY) begin
                            shift_ff <= rx_shifted;
                        end else if (slot_ff == `SCL_SLOT_PARITY) begin
                            if (par_bit(shift_ff[8:1], parity_odd) != sync2_ff) begin
                                bad_par_ff    <= 1'b1;
                                parity_err_ff <= 1'b1;
                                rxdata_ff     <= rx_word;
                            end else if (rx_buf_full_ff & ~(wr_stat & ~wb_dat_in[`SCL_STAT_RX_FULL])) begin
                                overrun_ff <= 1'b1;
                            end else begin
                                rxdata_ff      <= rx_word;
                                rx_buf_full_ff <= 1'b1;
                            end
                        end else if (slot_ff == `SCL_SLOT_ERRSIG) begin
                            err_drive_ff <= bad_par_ff;
                        end else begin
                            err_drive_ff <= 1'b0;
                        end
                    end else if (slot_ff == `SCL_SLOT_LAST && cnt_ff == `SCL_BASE_LAST) begin
                        busy_ff <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // scl_link
`default_nettype wire
